// ===== rtl/fdw_regs.svh
`ifndef FDW_REGS_SVH
`define FDW_REGS_SVH

// ----------------------------------------------------------------------------
// Window layout
// ----------------------------------------------------------------------------
`define FDW_SMALL_REG_BASE  17'h00800
`define FDW_LARGE_REG_BASE  17'h08000
`define FDW_LARGE_HOLE_TOP  3'b010
`define FDW_BOOT_WORDS      1024
`define FDW_DL_BASE         10'h200
`define FDW_PAGE_WORDS      10'h200
`define FDW_UID_WORDS       4'h8

// ----------------------------------------------------------------------------
// Paged RAM registers, same address in both windows
// ----------------------------------------------------------------------------
`define FDW_UNLOCK_ADDR     17'h00030
`define FDW_PAGE_SEL_ADDR   17'h00070
`define FDW_UID_DL_ADDR     17'h00080
`define FDW_UNLOCK_CODE     8'h71
`define FDW_SEQ_BIT         7
`define FDW_PAGE_ZERO       8'h00

// ----------------------------------------------------------------------------
// Communication registers, low 13 address bits, prefix selects the window
// ----------------------------------------------------------------------------
`define FDW_ID_PRIMARY_KEY  13'h1400
`define FDW_BURST_WR_KEY    13'h1402
`define FDW_BURST_LEAVE_KEY 13'h1404
`define FDW_STATUS_KEY      13'h1406
`define FDW_ID_INVERSE_KEY  13'h1422
`define FDW_BURST_RD_KEY    13'h1424
`define FDW_SMALL_PREFIX    4'h0
`define FDW_LARGE_PREFIX    4'h4
`define FDW_BURST_WMASK     16'h3F02
`define FDW_BURST_RESET     16'h0000
`define FDW_BURST_EN_BIT    1
`define FDW_STATUS_BUSY_BIT 0

// ----------------------------------------------------------------------------
// Host controller software registers
// ----------------------------------------------------------------------------
`define FDW_HC_ADDR         3'h0
`define FDW_HC_DATA         3'h1
`define FDW_HC_CMD          3'h2
`define FDW_HC_STATUS       3'h3
`define FDW_HC_RESULT       3'h4

`endif

// ===== rtl/fdw_pkg.sv
`default_nettype none

package fdw_pkg;

  typedef enum logic [1:0] {
    DL_IDLE = 2'b00,
    DL_PAGE = 2'b01,
    DL_UID  = 2'b10
  } fdw_dl_state_type;

  typedef enum logic [1:0] {
    OP_READ     = 2'b00,
    OP_WRITE    = 2'b01,
    OP_PAGE_SEL = 2'b10,
    OP_UID_LOAD = 2'b11
  } fdw_op_type;

  typedef enum logic [2:0] {
    HS_IDLE      = 3'b000,
    HS_UNLOCK    = 3'b001,
    HS_READ_WAIT = 3'b010,
    HS_POLL      = 3'b011,
    HS_POLL_WAIT = 3'b100
  } fdw_host_state_type;

endpackage : fdw_pkg

`default_nettype wire

// ===== rtl/fdw_if.sv
`default_nettype none

interface fdw_if;
  logic [16:0] addr;
  logic [15:0] wdata;
  logic        we;
  logic        re;
  logic [15:0] rdata;

  modport dev (input addr, input wdata, input we, input re, output rdata);
  modport host (output addr, output wdata, output we, output re, input rdata);
endinterface : fdw_if

`default_nettype wire

// ===== rtl/fdw_device.sv
`include "fdw_regs.svh"
`default_nettype none

// Behaviour
// - Small window: 2KB boot block at zero.
// - Small window: registers at base 0800H.
// - Large window: registers at base 8000H.
// - Window size follows configuration input.
// - Write-only unlock register at 0030.
// - Only code 71H arms one write.
// - Page select ignored unless just unlocked.
// - Accepted page select loads one 1KB page.
// - Sequential flag loads follow-on page.
// - Only page 00H, same as reset.
// - ID download writes 16 bytes at offset 0.
// - ID download needs unlock; RAM reads keep arming.
// - Host polls ready before reading ID.
// - Two fixed read-only identifier registers.
// - Second identifier is bitwise inverse.
// - Separate burst read and write registers.
// - Burst fields writable, others read zero.
// - Burst enable gates write burst start only.
// - Host bursts only with DMA transfers.
// - Exit write ends burst write unless a start coincides.
// - Reserved zero bits read as zero.
// - Documented reset values after reset.
module fdw_device
  import fdw_pkg::*;
#(
  parameter logic [15:0]  ID_VALUE  = 16'h5A3C,  // Arbitrary identifier.
  parameter logic [127:0] SERIAL_NO = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  fdw_if.dev               bus,
  input  wire logic        window_large_i,
  input  wire logic        fill_valid_i,
  input  wire logic [15:0] fill_data_i,
  input  wire logic        burst_write_start_i,
  output logic             download_req_o,
  output logic [7:0]       download_page_o,
  output logic             busy_o,
  output logic             burst_write_active_o,
  output logic [15:0]      burst_read_params_o,
  output logic [15:0]      burst_write_params_o
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [15:0]      boot_ram [`FDW_BOOT_WORDS];
  fdw_dl_state_type state_reg;
  logic [9:0]       count_reg;
  logic [7:0]       page_reg;
  logic [7:0]       next_page_reg;
  logic             armed_reg;
  logic             busy_reg;
  logic             burst_active_reg;
  logic [15:0]      burst_rd_reg;
  logic [15:0]      burst_wr_reg;
  logic [15:0]      reg_q_reg;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic [12:0] key;
  logic        in_regs;
  logic        in_boot;
  logic        wr_unlock;
  logic        wr_page;
  logic        wr_uid;
  logic        page_ok;
  logic [7:0]  page_next;
  logic        paged_addr;
  logic        ram_read;

  assign key = bus.addr[12:0];

  always_comb begin
    if (window_large_i) begin
      in_regs = (bus.addr[16:13] == `FDW_LARGE_PREFIX);
      in_boot = (bus.addr[16:14] != `FDW_LARGE_HOLE_TOP);
    end else begin
      in_regs = (bus.addr[16:13] == `FDW_SMALL_PREFIX)
                && (bus.addr >= `FDW_SMALL_REG_BASE);
      in_boot = (bus.addr < `FDW_SMALL_REG_BASE);
    end
  end

  assign wr_unlock = bus.we && (bus.addr == `FDW_UNLOCK_ADDR);
  assign wr_page   = bus.we && (bus.addr == `FDW_PAGE_SEL_ADDR);
  assign wr_uid    = bus.we && (bus.addr == `FDW_UID_DL_ADDR);

  // The paged registers are write-only and sit inside the boot block, so they read zero.
  assign paged_addr = (bus.addr == `FDW_UNLOCK_ADDR) || (bus.addr == `FDW_PAGE_SEL_ADDR)
                      || (bus.addr == `FDW_UID_DL_ADDR);
  assign ram_read   = bus.re && in_boot && !paged_addr;

  // A sequential request follows the chain; a direct one must name page zero.
  always_comb begin
    if (bus.wdata[`FDW_SEQ_BIT]) begin
      page_next = next_page_reg;
      page_ok   = 1'b1;
    end else begin
      page_next = `FDW_PAGE_ZERO;
      page_ok   = (bus.wdata[7:0] == `FDW_PAGE_ZERO);
    end
  end

  // --------------------------------------------------------------------------
  // Unlock arming
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_reg <= 1'b0;
    end else if (bus.we) begin
      armed_reg <= wr_unlock && (bus.wdata[7:0] == `FDW_UNLOCK_CODE);
    end else if (bus.re && !ram_read) begin
      armed_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Download engine
  // --------------------------------------------------------------------------
  // Reset leaves the engine loading page zero, so page zero and reset agree.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg     <= DL_PAGE;
      count_reg     <= 10'h000;
      page_reg      <= `FDW_PAGE_ZERO;
      next_page_reg <= `FDW_PAGE_ZERO;
    end else begin
      case (state_reg)
        DL_IDLE: begin
          count_reg <= 10'h000;
          if (wr_page && armed_reg && page_ok) begin
            state_reg <= DL_PAGE;
            page_reg  <= page_next;
          end else if (wr_uid && armed_reg) begin
            state_reg <= DL_UID;
          end
        end
        DL_PAGE: begin
          if (fill_valid_i) begin
            count_reg <= count_reg + 10'h001;
            if (count_reg == `FDW_PAGE_WORDS - 10'h001) begin
              state_reg     <= DL_IDLE;
              next_page_reg <= page_reg + 8'h01;
            end
          end
        end
        DL_UID: begin
          count_reg <= count_reg + 10'h001;
          if (count_reg == {6'h00, `FDW_UID_WORDS} - 10'h001) begin
            state_reg <= DL_IDLE;
          end
        end
        default: begin
          state_reg <= DL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      download_req_o  <= 1'b1;
      download_page_o <= `FDW_PAGE_ZERO;
      busy_reg        <= 1'b1;
    end else begin
      if (state_reg == DL_IDLE) begin
        download_req_o <= wr_page && armed_reg && page_ok;
        busy_reg       <= (wr_page && armed_reg && page_ok) || (wr_uid && armed_reg);
        if (wr_page && armed_reg && page_ok) begin
          download_page_o <= page_next;
        end
      end else if (state_reg == DL_PAGE && fill_valid_i
                   && count_reg == `FDW_PAGE_WORDS - 10'h001) begin
        download_req_o <= 1'b0;
        busy_reg       <= 1'b0;
      end else if (state_reg == DL_UID
                   && count_reg == {6'h00, `FDW_UID_WORDS} - 10'h001) begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign busy_o = busy_reg;

  // Words go into the downloadable half; the serial number starts at its base.
  always_ff @(posedge clock_i) begin
    if (state_reg == DL_PAGE && fill_valid_i) begin
      boot_ram[`FDW_DL_BASE + count_reg[8:0]] <= fill_data_i;
    end else if (state_reg == DL_UID) begin
      boot_ram[`FDW_DL_BASE + count_reg[8:0]] <= SERIAL_NO[count_reg[2:0] * 16 +: 16];
    end
  end

  // --------------------------------------------------------------------------
  // Burst parameters
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_rd_reg <= `FDW_BURST_RESET;
      burst_wr_reg <= `FDW_BURST_RESET;
    end else if (bus.we && in_regs) begin
      if (key == `FDW_BURST_RD_KEY) begin
        burst_rd_reg <= bus.wdata & `FDW_BURST_WMASK;
      end else if (key == `FDW_BURST_WR_KEY) begin
        burst_wr_reg <= bus.wdata & `FDW_BURST_WMASK;
      end
    end
  end

  // A start in the same cycle as an exit write wins, so no request is lost.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_active_reg <= 1'b0;
    end else if (burst_write_start_i && burst_wr_reg[`FDW_BURST_EN_BIT]) begin
      burst_active_reg <= 1'b1;
    end else if (bus.we && in_regs && key == `FDW_BURST_LEAVE_KEY) begin
      burst_active_reg <= 1'b0;
    end
  end

  assign burst_write_active_o = burst_active_reg;
  assign burst_read_params_o  = burst_rd_reg;
  assign burst_write_params_o = burst_wr_reg;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // The RAM word lands in the same flop as the registers, so read data leave a flop.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_q_reg <= 16'h0000;
    end else if (bus.re) begin
      reg_q_reg <= 16'h0000;
      if (ram_read) begin
        reg_q_reg <= boot_ram[bus.addr[10:1]];
      end else if (in_regs) begin
        if (key == `FDW_ID_PRIMARY_KEY) begin
          reg_q_reg <= ID_VALUE;
        end else if (key == `FDW_ID_INVERSE_KEY) begin
          reg_q_reg <= ~ID_VALUE;
        end else if (key == `FDW_BURST_RD_KEY) begin
          reg_q_reg <= burst_rd_reg;
        end else if (key == `FDW_BURST_WR_KEY) begin
          reg_q_reg <= burst_wr_reg;
        end else if (key == `FDW_STATUS_KEY) begin
          reg_q_reg <= {15'h0000, busy_reg};
        end
      end
    end
  end

  assign bus.rdata = reg_q_reg;

endmodule : fdw_device

`default_nettype wire

// ===== rtl/fdw_host.sv
`include "fdw_regs.svh"
`default_nettype none

module fdw_host
  import fdw_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  fdw_if.host              bus,
  input  wire logic        window_large_i,
  input  wire logic [2:0]  sw_addr_i,
  input  wire logic [16:0] sw_wdata_i,
  input  wire logic        sw_we_i,
  input  wire logic        sw_re_i,
  output logic [16:0]      sw_rdata_o
);

  // --------------------------------------------------------------------------
  // Software registers and bus drivers
  // --------------------------------------------------------------------------
  fdw_host_state_type state_reg;
  fdw_op_type         op_reg;
  logic [16:0]        addr_reg;
  logic [15:0]        data_reg;
  logic [15:0]        result_reg;
  logic [16:0]        bus_addr_reg;
  logic [15:0]        bus_wdata_reg;
  logic               bus_we_reg;
  logic               bus_re_reg;
  logic [16:0]        reg_base;
  logic [15:0]        plain_wdata;

  assign bus.addr  = bus_addr_reg;
  assign bus.wdata = bus_wdata_reg;
  assign bus.we    = bus_we_reg;
  assign bus.re    = bus_re_reg;

  assign reg_base = window_large_i ? `FDW_LARGE_REG_BASE : 17'h00000;

  // Reserved bits are sent with the values the device expects of them.
  always_comb begin
    plain_wdata = data_reg;
    if (addr_reg[12:0] == `FDW_BURST_RD_KEY || addr_reg[12:0] == `FDW_BURST_WR_KEY) begin
      plain_wdata = data_reg & `FDW_BURST_WMASK;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Only single plain cycles are issued; bursts are left to a DMA engine.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg     <= HS_IDLE;
      op_reg        <= OP_READ;
      bus_addr_reg  <= 17'h00000;
      bus_wdata_reg <= 16'h0000;
      bus_we_reg    <= 1'b0;
      bus_re_reg    <= 1'b0;
      result_reg    <= 16'h0000;
    end else begin
      bus_we_reg <= 1'b0;
      bus_re_reg <= 1'b0;
      case (state_reg)
        HS_IDLE: begin
          if (sw_we_i && sw_addr_i == `FDW_HC_CMD) begin
            op_reg <= fdw_op_type'(sw_wdata_i[1:0]);
            if (sw_wdata_i[1:0] == OP_READ) begin
              bus_addr_reg <= addr_reg;
              bus_re_reg   <= 1'b1;
              state_reg    <= HS_READ_WAIT;
            end else if (sw_wdata_i[1:0] == OP_WRITE) begin
              bus_addr_reg  <= addr_reg;
              bus_wdata_reg <= plain_wdata;
              bus_we_reg    <= 1'b1;
            end else begin
              bus_addr_reg  <= `FDW_UNLOCK_ADDR;
              bus_wdata_reg <= {8'h00, `FDW_UNLOCK_CODE};
              bus_we_reg    <= 1'b1;
              state_reg     <= HS_UNLOCK;
            end
          end
        end
        HS_UNLOCK: begin
          bus_we_reg <= 1'b1;
          if (op_reg == OP_PAGE_SEL) begin
            bus_addr_reg  <= `FDW_PAGE_SEL_ADDR;
            bus_wdata_reg <= {8'h00, data_reg[7:0]};
            state_reg     <= HS_IDLE;
          end else begin
            bus_addr_reg  <= `FDW_UID_DL_ADDR;
            bus_wdata_reg <= 16'h0000;
            state_reg     <= HS_POLL;
          end
        end
        HS_READ_WAIT: begin
          // Read data stand in the cycle after the strobe, so the strobe edge is skipped.
          if (!bus_re_reg) begin
            result_reg <= bus.rdata;
            state_reg  <= HS_IDLE;
          end
        end
        HS_POLL: begin
          bus_addr_reg <= reg_base | {4'h0, `FDW_STATUS_KEY};
          bus_re_reg   <= 1'b1;
          state_reg    <= HS_POLL_WAIT;
        end
        HS_POLL_WAIT: begin
          if (bus_re_reg) begin
            state_reg <= HS_POLL_WAIT;
          end else if (bus.rdata[`FDW_STATUS_BUSY_BIT]) begin
            state_reg <= HS_POLL;
          end else begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Software port
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reg <= 17'h00000;
      data_reg <= 16'h0000;
    end else if (sw_we_i && sw_addr_i == `FDW_HC_ADDR) begin
      addr_reg <= sw_wdata_i;
    end else if (sw_we_i && sw_addr_i == `FDW_HC_DATA) begin
      data_reg <= sw_wdata_i[15:0];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_rdata_o <= 17'h00000;
    end else if (sw_re_i) begin
      if (sw_addr_i == `FDW_HC_ADDR) begin
        sw_rdata_o <= addr_reg;
      end else if (sw_addr_i == `FDW_HC_DATA) begin
        sw_rdata_o <= {1'b0, data_reg};
      end else if (sw_addr_i == `FDW_HC_STATUS) begin
        sw_rdata_o <= {16'h0000, state_reg != HS_IDLE};
      end else if (sw_addr_i == `FDW_HC_RESULT) begin
        sw_rdata_o <= {1'b0, result_reg};
      end else begin
        sw_rdata_o <= 17'h00000;
      end
    end
  end

endmodule : fdw_host

`default_nettype wire

// ===== tb/fdw_checker.sv
`include "fdw_regs.svh"
`default_nettype none

module fdw_checker #(
  parameter logic [15:0] ID_VALUE = 16'h5A3C
) (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        window_large_i,
  input wire logic [16:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        we,
  input wire logic        re,
  input wire logic [15:0] rdata
);
  // ----------------------------------------
  // Shadows of the writable burst fields
  // ----------------------------------------
  logic [3:0]  pfx;
  logic [15:0] rd_shadow_reg;
  logic [15:0] wr_shadow_reg;

  assign pfx = window_large_i ? `FDW_LARGE_PREFIX : `FDW_SMALL_PREFIX;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_shadow_reg <= `FDW_BURST_RESET;
      wr_shadow_reg <= `FDW_BURST_RESET;
    end else if (we && addr == {pfx, `FDW_BURST_RD_KEY}) begin
      rd_shadow_reg <= wdata & `FDW_BURST_WMASK;
    end else if (we && addr == {pfx, `FDW_BURST_WR_KEY}) begin
      wr_shadow_reg <= wdata & `FDW_BURST_WMASK;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  a_id_primary_value: assert property (
    re && addr == {pfx, `FDW_ID_PRIMARY_KEY} |=> rdata == ID_VALUE)
    else $error("primary identifier read wrong");
  a_id_inverse_value: assert property (
    re && addr == {pfx, `FDW_ID_INVERSE_KEY} |=> rdata == ~ID_VALUE)
    else $error("inverse identifier read wrong");
  a_rd_reserved_zero: assert property (
    re && addr == {pfx, `FDW_BURST_RD_KEY} |=> (rdata & ~`FDW_BURST_WMASK) == 16'h0000)
    else $error("burst read register reserved bits set");
  a_wr_reserved_zero: assert property (
    re && addr == {pfx, `FDW_BURST_WR_KEY} |=> (rdata & ~`FDW_BURST_WMASK) == 16'h0000)
    else $error("burst write register reserved bits set");
  a_rd_read_back: assert property (
    re && addr == {pfx, `FDW_BURST_RD_KEY} |=> rdata == rd_shadow_reg)
    else $error("burst read register lost its value");
  a_wr_read_back: assert property (
    re && addr == {pfx, `FDW_BURST_WR_KEY} |=> rdata == wr_shadow_reg)
    else $error("burst write register lost its value");
  a_paged_reads_zero: assert property (
    re && (addr == `FDW_UNLOCK_ADDR || addr == `FDW_PAGE_SEL_ADDR || addr == `FDW_UID_DL_ADDR)
    |=> rdata == 16'h0000)
    else $error("paged register read not zero");
  a_exit_reads_zero: assert property (
    re && addr == {pfx, `FDW_BURST_LEAVE_KEY} |=> rdata == 16'h0000)
    else $error("exit register read not zero");

  c_id_read: cover property (re && addr == {pfx, `FDW_ID_PRIMARY_KEY});
  c_burst_write: cover property (we && addr == {pfx, `FDW_BURST_WR_KEY});
  c_exit_write: cover property (we && addr == {pfx, `FDW_BURST_LEAVE_KEY});
endmodule : fdw_checker

`default_nettype wire

// ===== tb/flash_drive_host_register_window_tb.sv
`default_nettype none

module flash_drive_host_register_window_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0]  ID = 16'h5A3C;  // Arbitrary identifier value.
  localparam logic [127:0] SN = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_F00D;
  localparam logic [15:0]  M  = 16'h3F02;

  logic        clock_i = 1'b0;
  logic        nrst_i  = 1'b0;
  logic        win     = 1'b0;
  logic        fv      = 1'b0;
  logic        bws     = 1'b0;
  logic        swe     = 1'b0;
  logic        sre     = 1'b0;
  logic [15:0] fd      = 16'h0000;
  logic [2:0]  sa      = 3'h0;
  logic [16:0] swd     = 17'h00000;
  logic [16:0] srd;
  logic        dreq, busy, bwa;
  logic [7:0]  dpg;
  logic [15:0] brp, bwp;
  logic [15:0] pm [512];
  int          err_total = 0;
  int          checks    = 0;
  int          cnt       = 0;

  fdw_if bus_if ();

  fdw_device #(.ID_VALUE(ID), .SERIAL_NO(SN)) i_fdw_device (
    .clock_i(clock_i), .nrst_i(nrst_i), .bus(bus_if), .window_large_i(win),
    .fill_valid_i(fv), .fill_data_i(fd), .burst_write_start_i(bws),
    .download_req_o(dreq), .download_page_o(dpg), .busy_o(busy),
    .burst_write_active_o(bwa), .burst_read_params_o(brp), .burst_write_params_o(bwp));

  fdw_host i_fdw_host (
    .clock_i(clock_i), .nrst_i(nrst_i), .bus(bus_if), .window_large_i(win),
    .sw_addr_i(sa), .sw_wdata_i(swd), .sw_we_i(swe), .sw_re_i(sre), .sw_rdata_o(srd));

  fdw_checker #(.ID_VALUE(ID)) i_fdw_checker (
    .clock_i(clock_i), .nrst_i(nrst_i), .window_large_i(win), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .we(bus_if.we), .re(bus_if.re), .rdata(bus_if.rdata));

  initial forever #4 clock_i = ~clock_i;

  // ----------------------------------------
  // Page source and its model
  // ----------------------------------------
  // The source stalls at random so the fill handshake sees gaps.
  always @(posedge clock_i) begin
    if (nrst_i && dreq && fv) begin
      pm[cnt % 512] = fd;
      cnt = cnt + 1;
    end
    fv <= ($urandom % 4) != 0;
    fd <= 16'($urandom);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic sw_wr(logic [2:0] a, logic [16:0] d);
    @(posedge clock_i);
    sa  <= a;
    swd <= d;
    swe <= 1'b1;
    @(posedge clock_i);
    swe <= 1'b0;
  endtask : sw_wr

  task automatic sw_rd(logic [2:0] a, output logic [16:0] v);
    @(posedge clock_i);
    sa  <= a;
    sre <= 1'b1;
    @(posedge clock_i);
    sre <= 1'b0;
    @(posedge clock_i);
    v = srd;
  endtask : sw_rd

  task automatic op(logic [1:0] c, logic [16:0] a, logic [15:0] d);
    logic [16:0] v;
    sw_wr(3'h0, a);
    sw_wr(3'h1, {1'b0, d});
    sw_wr(3'h2, {15'h0, c});
    v = 17'h00001;
    for (int i = 0; i < 200 && v[0] !== 1'b0; i++) sw_rd(3'h3, v);
    chk("host status", 16'h0000, {15'h0, v[0]});
  endtask : op

  task automatic rd(logic [16:0] a, logic [15:0] exp);
    logic [16:0] v;
    op(2'h0, a, 16'h0000);
    sw_rd(3'h4, v);
    chk($sformatf("read %h", a), exp, v[15:0]);
  endtask : rd

  task automatic wt;
    for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge clock_i);
  endtask : wt

  task automatic rst(logic w);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    win    <= w;
    repeat (2) @(posedge clock_i);
    cnt = 0;
    nrst_i <= 1'b1;
    wt();
    chk("boot words", 16'h0200, 16'(cnt));
  endtask : rst

  task automatic sel(logic [7:0] d, logic ok, logic [7:0] pg);
    cnt = 0;
    op(2'h2, 17'h00000, {8'h00, d});
    chk("select busy", {15'h0, ok}, {15'h0, busy});
    if (ok) chk("select page", {8'h00, pg}, {8'h00, dpg});
    wt();
    chk("select words", ok ? 16'h0200 : 16'h0000, 16'(cnt));
  endtask : sel

  task automatic pulse(logic exp);
    @(posedge clock_i);
    bws <= 1'b1;
    @(posedge clock_i);
    bws <= 1'b0;
    @(posedge clock_i);
    chk("burst active", {15'h0, exp}, {15'h0, bwa});
  endtask : pulse

  task automatic sn_chk(logic exp);
    logic [127:0] a, b;
    logic [16:0]  v;
    for (int i = 0; i < 8; i++) begin
      op(2'h0, 17'h00400 + 17'(2 * i), 16'h0000);
      sw_rd(3'h4, v);
      a[16*i +: 16]     = v[15:0];
      b[112-16*i +: 16] = v[15:0];
    end
    chk("serial present", {15'h0, exp}, {15'h0, a === SN || b === SN});
  endtask : sn_chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [15:0] dr, dw;
    logic [16:0] wo [5];
    wo = '{17'h00030, 17'h00070, 17'h00080, 17'h01404, 17'h01500};
    dr = 16'($urandom(90));
    dw = 16'($urandom);
    rst(1'b0);
    rd(17'h01400, ID);
    rd(17'h01422, ~ID);
    rd(17'h00400, pm[0]);
    rd(17'h007FE, pm[511]);
    foreach (wo[i]) rd(wo[i], 16'h0000);
    op(2'h1, 17'h01424, dr);
    op(2'h1, 17'h01402, dw & ~16'h0002);
    rd(17'h01424, dr & M);
    rd(17'h01402, dw & M & ~16'h0002);
    chk("read params", dr & M, brp);
    pulse(1'b0);
    op(2'h1, 17'h01402, dw | 16'h0002);
    chk("write params", (dw | 16'h0002) & M, bwp);
    pulse(1'b1);
    op(2'h1, 17'h01404, dr);
    chk("burst left", 16'h0000, {15'h0, bwa});
    sel(8'h00, 1'b1, 8'h00);
    rd(17'h00402, pm[1]);
    sel(8'h80, 1'b1, 8'h01);
    sel(8'h05, 1'b0, 8'h00);
    op(2'h1, 17'h00070, 16'h0000);
    chk("unarmed select", 16'h0000, {15'h0, busy});
    op(2'h1, 17'h00030, 16'h0055);
    op(2'h1, 17'h00070, 16'h0000);
    chk("wrong code select", 16'h0000, {15'h0, busy});
    op(2'h1, 17'h00030, 16'h0071);
    op(2'h1, 17'h01402, 16'h0000);
    op(2'h1, 17'h00070, 16'h0000);
    chk("stale arm select", 16'h0000, {15'h0, busy});
    op(2'h1, 17'h00080, 16'h0000);
    wt();
    sn_chk(1'b0);
    op(2'h1, 17'h00030, 16'h0071);
    op(2'h0, 17'h00400, 16'h0000);
    op(2'h1, 17'h00080, 16'h0000);
    wt();
    sn_chk(1'b1);
    sel(8'h00, 1'b1, 8'h00);
    op(2'h3, 17'h00000, 16'h0000);
    sn_chk(1'b1);
    rd(17'h00410, pm[8]);
    rst(1'b1);
    rd(17'h09424, 16'h0000);
    rd(17'h09402, 16'h0000);
    chk("params reset", 16'h0000, brp | bwp);
    rd(17'h09400, ID);
    rd(17'h09422, ~ID);
    rd(17'h01400, pm[0]);
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clock_i);
    err_total++;
    $display("wrong value watchdog expected done seen hang");
    summarize();
  end
endmodule : flash_drive_host_register_window_tb

`default_nettype wire
